//--- pkg/rtc_i2c_pkg.sv
// Behaviour
// [RQ1] every byte shifted most significant bit first
// [RQ2] data changes only while clock is low
// [RQ3] ignore traffic until a start is seen
// [RQ4] starts ignored during the power-up sequence
// [RQ5] stop ends a transaction, back to standby
// [RQ6] receiver pulls data low on ninth clock
// [RQ7] acknowledge identification, word address, written data
// [RQ8] 1101111 clock space, 1010111 user memory
// [RQ9] direction bit one reads, zero writes
// [RQ10] acknowledge address byte only on a match
// [RQ11] one word address byte, pointer reset zero
// [RQ12] random read repeats the same target address
// [RQ13] write: start, id, address, data, stop
// [RQ14] read: write id, address, restart, read id
// [RQ15] device sends while controller keeps acknowledging
// [RQ16] pointer loaded from word address, increments
// [RQ17] pointer wraps to zero after 2Fh; in user memory the code wraps after 7Fh instead
// [RQ18] data pin released at power-up
// [RQ19] user memory holds 128 bytes, 00h-7Fh
// [RQ20] serial port disabled on backup supply
// [RQ21] unmatched address: no acknowledge, wait start
// [RQ22] start or stop mid-byte resyncs bit counter
package rtc_i2c_pkg;
  localparam logic [6:0] CLOCK_SPACE_ADDR  = 7'h6f;
  localparam logic [6:0] USER_SPACE_ADDR   = 7'h57;
  localparam int         USER_BYTES        = 128;
  localparam logic [7:0] CLOCK_SPACE_LAST  = 8'h2f;
  localparam logic [7:0] USER_SPACE_LAST   = 8'h7f;
  localparam logic [7:0] PTR_RESET         = 8'h00;
  localparam logic [3:0] BITS_PER_BYTE     = 4'h8;
  localparam logic [3:0] LAST_TX_BIT       = 4'h7;
  localparam int         SYS_CLK_PERIOD_NS = 20;
  localparam int         LINK_PERIOD_NS    = 2500;
  localparam int         QUARTER_CYCLES    =
    (LINK_PERIOD_NS / 4 + SYS_CLK_PERIOD_NS - 1) / SYS_CLK_PERIOD_NS;
  localparam logic [5:0] QUARTER_LAST      = 6'(QUARTER_CYCLES - 1);
  localparam logic [7:0] CMD_OFFSET        = 8'h00;
  localparam logic [7:0] TXDATA_OFFSET     = 8'h04;
  localparam logic [7:0] STATUS_OFFSET     = 8'h08;
  localparam logic [7:0] RXDATA_OFFSET     = 8'h0c;
  localparam int         CMD_START_BIT     = 0;
  localparam int         CMD_WRITE_BIT     = 1;
  localparam int         CMD_READ_BIT      = 2;
  localparam int         CMD_STOP_BIT      = 3;
  localparam int         CMD_ACK_BIT       = 4;
  localparam logic [1:0] RESP_OKAY         = 2'h0;
  localparam logic [1:0] RESP_SLVERR       = 2'h2;
endpackage : rtc_i2c_pkg

//--- pkg/i2c_link_if.sv
`timescale 1ns/1ps
interface i2c_link_if;
  logic scl_host_out;
  logic scl_host_oe_n;
  logic sda_host_out;
  logic sda_host_oe_n;
  logic sda_dev_out;
  logic sda_dev_oe_n;
  wire  scl_line;
  wire  sda_line;
  // open drain with pull-up: a released line reads high
  assign scl_line = scl_host_oe_n | scl_host_out;
  assign sda_line = (sda_host_oe_n | sda_host_out) & (sda_dev_oe_n | sda_dev_out);
  modport device (input scl_line, input sda_line, output sda_dev_out, output sda_dev_oe_n);
  modport host (input scl_line, input sda_line, output scl_host_out, output scl_host_oe_n,
                output sda_host_out, output sda_host_oe_n);
endinterface : i2c_link_if

//--- verilog/rtc_i2c_target.sv
`timescale 1ns/1ps
module rtc_i2c_target
  import rtc_i2c_pkg::*;
(
  input  wire logic       sys_clk_in,
  input  wire logic       reset_in,
  i2c_link_if.device      link,
  input  wire logic       powerup_busy_in,
  input  wire logic       backup_supply_in,
  output logic      [7:0] csr_rd_addr_out,
  input  wire logic [7:0] csr_rdata_in,
  output logic            csr_wr_out,
  output logic      [7:0] csr_wr_addr_out,
  output logic      [7:0] csr_wdata_out,
  output logic            busy_out
);
  typedef enum logic [2:0] {P_IDLE, P_ADDR, P_WADDR, P_WDATA, P_RDATA, P_IGNORE} phase_e;

  typedef struct packed {
    logic       scl_s1;
    logic       scl_s2;
    logic       scl_s3;
    logic       sda_s1;
    logic       sda_s2;
    logic       sda_s3;
    phase_e     phase;
    logic [3:0] cnt;
    logic [7:0] shift;
    logic [7:0] ptr;
    logic       user;
    logic       read;
    logic       ack;
    logic       mack;
    logic       sda_rel;
    logic       csr_wr;
    logic [7:0] csr_addr;
    logic [7:0] csr_wdata;
  } target_s;

  localparam target_s TARGET_RESET = '{
    scl_s1: 1'b1, scl_s2: 1'b1, scl_s3: 1'b1,
    sda_s1: 1'b1, sda_s2: 1'b1, sda_s3: 1'b1,
    phase: P_IDLE, cnt: 4'h0, shift: 8'h00, ptr: PTR_RESET,
    user: 1'b0, read: 1'b0, ack: 1'b0, mack: 1'b0, sda_rel: 1'b1,
    csr_wr: 1'b0, csr_addr: 8'h00, csr_wdata: 8'h00
  };

  target_s    q;
  target_s    d;
  logic [7:0] user_mem [USER_BYTES];
  logic       mem_we;
  logic       scl_rise;
  logic       scl_fall;
  logic       start_seen;
  logic       stop_seen;
  logic [7:0] rd_byte;
  logic [7:0] next_ptr;

  // only the second and third stages are looked at
  assign scl_rise   = q.scl_s2 & ~q.scl_s3;
  assign scl_fall   = ~q.scl_s2 & q.scl_s3;
  assign start_seen = q.scl_s2 & q.scl_s3 & ~q.sda_s2 & q.sda_s3; // see [RQ3]
  assign stop_seen  = q.scl_s2 & q.scl_s3 & q.sda_s2 & ~q.sda_s3; // see [RQ5]
  assign rd_byte    = q.user ? user_mem[q.ptr[6:0]] : csr_rdata_in;
  // see [RQ17]
  assign next_ptr   = (q.ptr == (q.user ? USER_SPACE_LAST : CLOCK_SPACE_LAST)) ?
                      PTR_RESET : 8'(q.ptr + 8'h01);

  always_comb
  begin
    d        = q;
    mem_we   = 1'b0;
    d.csr_wr = 1'b0;
    d.scl_s1 = link.scl_line;
    d.scl_s2 = q.scl_s1;
    d.scl_s3 = q.scl_s2;
    d.sda_s1 = link.sda_line;
    d.sda_s2 = q.sda_s1;
    d.sda_s3 = q.sda_s2;
    if (backup_supply_in)
    begin
      // port frozen; memory and pointer keep their contents
      d.phase   = P_IDLE; // see [RQ20]
      d.sda_rel = 1'b1;
      d.ack     = 1'b0;
    end
    else if (start_seen && !powerup_busy_in) // see [RQ4]
    begin
      // repeated start lands here too; pointer is kept for reads
      d.phase   = P_ADDR; // see [RQ22]
      d.cnt     = 4'h0;
      d.ack     = 1'b0;
      d.sda_rel = 1'b1;
    end
    else if (stop_seen)
    begin
      d.phase   = P_IDLE; // see [RQ5]
      d.cnt     = 4'h0;
      d.ack     = 1'b0;
      d.sda_rel = 1'b1;
    end
    else
    begin
      case (q.phase)
        P_ADDR, P_WADDR, P_WDATA:
        begin
          if (scl_rise && !q.ack)
          begin
            d.shift = {q.shift[6:0], q.sda_s2}; // see [RQ1]
            d.cnt   = 4'(q.cnt + 4'h1);
          end
          else if (scl_fall && q.ack)
          begin
            // release right after the ninth clock falls; after a read address, drive the first data bit instead
            d.ack     = 1'b0; // see [RQ6]
            d.sda_rel = 1'b1;
            d.cnt     = 4'h0;
            if (q.phase == P_ADDR && q.read)
            begin
              d.phase   = P_RDATA;
              d.shift   = rd_byte; // see [RQ16]
              d.sda_rel = rd_byte[7]; // see [RQ2]
              d.ptr     = next_ptr;
            end
            else if (q.phase == P_ADDR)
            begin
              d.phase = P_WADDR;
            end
            else
            begin
              d.phase = P_WDATA;
            end
          end
          else if (scl_fall && q.cnt == BITS_PER_BYTE)
          begin
            d.ack     = 1'b1; // see [RQ7]
            d.sda_rel = 1'b0; // see [RQ6]
            case (q.phase)
              P_ADDR:
              begin
                d.read = q.shift[0]; // see [RQ9]
                if (q.shift[7:1] == CLOCK_SPACE_ADDR) // see [RQ10]
                begin
                  d.user = 1'b0; // see [RQ8]
                end
                else if (q.shift[7:1] == USER_SPACE_ADDR)
                begin
                  d.user = 1'b1; // see [RQ19]
                end
                else
                begin
                  d.ack     = 1'b0; // see [RQ21]
                  d.sda_rel = 1'b1;
                  d.phase   = P_IGNORE;
                end
              end
              P_WADDR:
              begin
                d.ptr = q.shift; // see [RQ11]
              end
              default:
              begin
                if (q.user)
                begin
                  mem_we = 1'b1;
                end
                else
                begin
                  d.csr_wr    = 1'b1;
                  d.csr_addr  = q.ptr;
                  d.csr_wdata = q.shift;
                end
                d.ptr = next_ptr;
              end
            endcase
          end
        end
        P_RDATA:
        begin
          if (!q.ack)
          begin
            if (scl_fall)
            begin
              d.cnt   = 4'(q.cnt + 4'h1);
              d.shift = {q.shift[6:0], 1'b0};
              if (q.cnt == LAST_TX_BIT)
              begin
                d.sda_rel = 1'b1; // see [RQ6]
                d.ack     = 1'b1;
              end
              else
              begin
                d.sda_rel = q.shift[6]; // see [RQ1]
              end
            end
          end
          else
          begin
            if (scl_rise)
            begin
              d.mack = ~q.sda_s2;
            end
            if (scl_fall)
            begin
              if (q.mack) // see [RQ15]
              begin
                d.shift   = rd_byte; // see [RQ16]
                d.sda_rel = rd_byte[7];
                d.ptr     = next_ptr;
                d.ack     = 1'b0;
                d.cnt     = 4'h0;
              end
              else
              begin
                d.phase = P_IGNORE;
                d.ack   = 1'b0;
              end
            end
          end
        end
        P_IDLE, P_IGNORE:
        begin
          d.sda_rel = 1'b1;
        end
        default:
        begin
          d.phase = P_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge sys_clk_in)
  begin
    if (reset_in)
    begin
      q <= TARGET_RESET; // see [RQ18]
    end
    else
    begin
      q <= d;
    end
  end

  // no reset: memory contents survive, as battery-backed storage would
  always_ff @(posedge sys_clk_in)
  begin
    if (mem_we)
    begin
      user_mem[q.ptr[6:0]] <= q.shift;
    end
  end

  assign link.sda_dev_out  = 1'b0;
  assign link.sda_dev_oe_n = q.sda_rel;
  assign csr_rd_addr_out   = q.ptr;
  assign csr_wr_out        = q.csr_wr;
  assign csr_wr_addr_out   = q.csr_addr;
  assign csr_wdata_out     = q.csr_wdata;
  assign busy_out          = (q.phase != P_IDLE);
endmodule : rtc_i2c_target

//--- verilog/rtc_i2c_controller.sv
// Local design decision: the AXI4-Lite slave port.
`timescale 1ns/1ps
module rtc_i2c_controller
  import rtc_i2c_pkg::*;
(
  input  wire logic        sys_clk_in,
  input  wire logic        reset_in,
  i2c_link_if.host         link,
  input  wire logic [7:0]  awaddr_in,
  input  wire logic        awvalid_in,
  output logic             awready_out,
  input  wire logic [31:0] wdata_in,
  input  wire logic [3:0]  wstrb_in,
  input  wire logic        wvalid_in,
  output logic             wready_out,
  output logic      [1:0]  bresp_out,
  output logic             bvalid_out,
  input  wire logic        bready_in,
  input  wire logic [7:0]  araddr_in,
  input  wire logic        arvalid_in,
  output logic             arready_out,
  output logic      [31:0] rdata_out,
  output logic      [1:0]  rresp_out,
  output logic             rvalid_out,
  input  wire logic        rready_in
);
  typedef enum logic [1:0] {S_IDLE, S_START, S_BIT, S_STOP} stage_e;

  typedef struct packed {
    logic        scl_s1;
    logic        sda_s1;
    logic        sda_s2;
    logic [5:0]  div;
    stage_e      stage;
    logic [1:0]  ph;
    logic [3:0]  cnt;
    logic [8:0]  shift;
    logic [7:0]  rx;
    logic [7:0]  tx;
    logic        read;
    logic        ackbit;
    logic        nack;
    logic        pend_start;
    logic        pend_byte;
    logic        pend_stop;
    logic        scl_rel;
    logic        sda_rel;
    logic        aw_ok;
    logic [7:0]  awaddr;
    logic        w_ok;
    logic [31:0] wdata;
    logic        wstrb0;
    logic        bvalid;
    logic [1:0]  bresp;
    logic        rvalid;
    logic [31:0] rdata;
    logic [1:0]  rresp;
  } ctrl_s;

  ctrl_s q;
  ctrl_s d;
  logic  tick;
  logic  busy;

  assign tick = (q.div == QUARTER_LAST);
  assign busy = (q.stage != S_IDLE) | q.pend_start | q.pend_byte | q.pend_stop;

  always_comb
  begin
    d        = q;
    d.scl_s1 = link.scl_line;
    d.sda_s1 = link.sda_line;
    d.sda_s2 = q.sda_s1;
    d.div    = tick ? 6'h00 : 6'(q.div + 6'h01);
    case (q.stage)
      S_IDLE:
      begin
        d.ph = 2'h0;
        if (q.pend_start)
        begin
          d.pend_start = 1'b0;
          d.stage      = S_START;
        end
        else if (q.pend_byte)
        begin
          d.pend_byte = 1'b0;
          d.stage     = S_BIT;
          d.cnt       = 4'h0;
          // read releases data for eight bits, then answers
          d.shift     = q.read ? {8'hff, ~q.ackbit} : {q.tx, 1'b1}; // see [RQ15]
        end
        else if (q.pend_stop)
        begin
          d.pend_stop = 1'b0;
          d.stage     = S_STOP;
        end
      end
      S_START:
      begin
        if (tick)
        begin
          d.ph = 2'(q.ph + 2'h1);
          case (q.ph)
            2'h0: d.sda_rel = 1'b1;
            2'h1: d.scl_rel = 1'b1;
            2'h2: d.sda_rel = 1'b0; // see [RQ3]
            default:
            begin
              d.scl_rel = 1'b0;
              d.stage   = S_IDLE;
            end
          endcase
        end
      end
      S_BIT:
      begin
        if (tick)
        begin
          d.ph = 2'(q.ph + 2'h1);
          case (q.ph)
            2'h0: d.sda_rel = q.shift[8]; // see [RQ2]
            2'h1: d.scl_rel = 1'b1;
            2'h2:
            begin
              if (q.cnt != BITS_PER_BYTE)
              begin
                if (q.read)
                begin
                  d.rx = {q.rx[6:0], q.sda_s2}; // see [RQ1]
                end
              end
              else if (!q.read)
              begin
                d.nack = q.sda_s2; // see [RQ6]
              end
            end
            default:
            begin
              d.scl_rel = 1'b0;
              d.shift   = {q.shift[7:0], 1'b1};
              d.cnt     = 4'(q.cnt + 4'h1);
              if (q.cnt == BITS_PER_BYTE)
              begin
                d.stage = S_IDLE;
              end
            end
          endcase
        end
      end
      S_STOP:
      begin
        if (tick)
        begin
          d.ph = 2'(q.ph + 2'h1);
          case (q.ph)
            2'h0: d.sda_rel = 1'b0;
            2'h1: d.scl_rel = 1'b1;
            2'h2: d.sda_rel = 1'b1; // see [RQ5]
            default: d.stage = S_IDLE;
          endcase
        end
      end
      default:
      begin
        d.stage = S_IDLE;
      end
    endcase

    if (awvalid_in && !q.aw_ok)
    begin
      d.aw_ok  = 1'b1;
      d.awaddr = awaddr_in;
    end
    if (wvalid_in && !q.w_ok)
    begin
      d.w_ok   = 1'b1;
      d.wdata  = wdata_in;
      d.wstrb0 = wstrb_in[0];
    end
    if (q.bvalid && bready_in)
    begin
      d.bvalid = 1'b0;
    end
    if (q.aw_ok && q.w_ok && !q.bvalid)
    begin
      d.aw_ok  = 1'b0;
      d.w_ok   = 1'b0;
      d.bvalid = 1'b1;
      d.bresp  = RESP_OKAY;
      case (q.awaddr)
        CMD_OFFSET:
        begin
          // commands while busy are dropped; software polls status first
          if (q.wstrb0 && !busy)
          begin
            d.pend_start = q.wdata[CMD_START_BIT]; // see [RQ14]
            d.pend_byte  = q.wdata[CMD_WRITE_BIT] | q.wdata[CMD_READ_BIT];
            d.read       = q.wdata[CMD_READ_BIT]; // see [RQ9]
            d.pend_stop  = q.wdata[CMD_STOP_BIT]; // see [RQ13]
            d.ackbit     = q.wdata[CMD_ACK_BIT];
            d.nack       = 1'b0;
          end
        end
        TXDATA_OFFSET:
        begin
          if (q.wstrb0)
          begin
            d.tx = q.wdata[7:0]; // see [RQ12]
          end
        end
        STATUS_OFFSET, RXDATA_OFFSET: d.bresp = RESP_OKAY;
        default: d.bresp = RESP_SLVERR;
      endcase
    end

    if (q.rvalid && rready_in)
    begin
      d.rvalid = 1'b0;
    end
    else if (arvalid_in && !q.rvalid)
    begin
      d.rvalid = 1'b1;
      d.rresp  = RESP_OKAY;
      case (araddr_in)
        TXDATA_OFFSET: d.rdata = {24'h000000, q.tx};
        STATUS_OFFSET: d.rdata = {30'h00000000, q.nack, busy};
        RXDATA_OFFSET: d.rdata = {24'h000000, q.rx};
        CMD_OFFSET:    d.rdata = 32'h00000000;
        default:
        begin
          d.rdata = 32'h00000000;
          d.rresp = RESP_SLVERR;
        end
      endcase
    end
  end

  always_ff @(posedge sys_clk_in)
  begin
    if (reset_in)
    begin
      q         <= '0;
      q.scl_s1  <= 1'b1;
      q.sda_s1  <= 1'b1;
      q.sda_s2  <= 1'b1;
      q.scl_rel <= 1'b1;
      q.sda_rel <= 1'b1;
    end
    else
    begin
      q <= d;
    end
  end

  assign link.scl_host_out  = 1'b0;
  assign link.scl_host_oe_n = q.scl_rel;
  assign link.sda_host_out  = 1'b0;
  assign link.sda_host_oe_n = q.sda_rel;
  assign awready_out        = ~q.aw_ok;
  assign wready_out         = ~q.w_ok;
  assign bvalid_out         = q.bvalid;
  assign bresp_out          = q.bresp;
  assign arready_out        = ~q.rvalid;
  assign rvalid_out         = q.rvalid;
  assign rdata_out          = q.rdata;
  assign rresp_out          = q.rresp;
endmodule : rtc_i2c_controller

//--- test/rtc_i2c_checker.sv
`timescale 1ns/1ps
module rtc_i2c_checker
(
  input wire logic sys_clk_in,
  input wire logic reset_in,
  input wire logic scl_line,
  input wire logic sda_line,
  input wire logic scl_host_oe_n,
  input wire logic sda_host_oe_n,
  input wire logic sda_dev_oe_n,
  input wire logic powerup_busy_in,
  input wire logic backup_supply_in
);
  logic sda_q;
  logic scl_q;
  logic frame_q;
  default clocking cb @(posedge sys_clk_in);
  endclocking
  default disable iff (reset_in);
  // frame tracking from the wire itself, independent of either end
  always_ff @(posedge sys_clk_in)
  begin
    if (reset_in)
    begin
      sda_q   <= 1'b1;
      scl_q   <= 1'b1;
      frame_q <= 1'b0;
    end
    else
    begin
      sda_q <= sda_line;
      scl_q <= scl_line;
      if (scl_q && scl_line && sda_q && !sda_line)
        frame_q <= 1'b1;
      else if (scl_q && scl_line && !sda_q && sda_line)
        frame_q <= 1'b0;
    end
  end
  a_lines_released: assert property (
    $fell(reset_in) |-> sda_dev_oe_n && sda_host_oe_n && scl_host_oe_n)
    else $error("a line is driven right after reset");
  a_dev_change_low: assert property (
    $changed(sda_dev_oe_n) && !backup_supply_in |-> !scl_line)
    else $error("device changed data while clock high");
  a_dev_drive_delay: assert property (
    $fell(sda_dev_oe_n) |-> !scl_line && !$past(scl_line)
    && ($past(scl_line, 2) || $past(scl_line, 3) || $past(scl_line, 4) || $past(scl_line, 5)
    || $past(scl_line, 6) || $past(scl_line, 7)))
    else $error("device drive not tied to a clock fall");
  a_dev_drive_hold: assert property (
    $fell(sda_dev_oe_n) |=> !sda_dev_oe_n [*8])
    else $error("device drive too short");
  a_drive_in_frame: assert property (
    !sda_dev_oe_n |-> frame_q)
    else $error("device drives outside a frame");
  a_backup_quiet: assert property (
    backup_supply_in |-> ##[1:2] sda_dev_oe_n)
    else $error("device drives on backup supply");
  a_powerup_quiet: assert property (
    powerup_busy_in |-> sda_dev_oe_n)
    else $error("device drives during power-up");
  a_host_setup: assert property (
    $changed(sda_host_oe_n) && !scl_line |-> !scl_line [*8])
    else $error("host data change too close to clock rise");
  c_dev_ack: cover property ($fell(sda_dev_oe_n));
  c_restart: cover property (frame_q && scl_q && scl_line && sda_q && !sda_line);
  c_backup: cover property ($fell(backup_supply_in));
endmodule : rtc_i2c_checker

//--- test/rtc_i2c_target_port_test.sv
`timescale 1ns/1ps
module rtc_sram_i2c_target_port_test
  import rtc_i2c_pkg::*;
;
  localparam logic [31:0] ST = 32'h1 << CMD_START_BIT;
  localparam logic [31:0] WR = 32'h1 << CMD_WRITE_BIT;
  localparam logic [31:0] RD = 32'h1 << CMD_READ_BIT;
  localparam logic [31:0] SP = 32'h1 << CMD_STOP_BIT;
  localparam logic [31:0] AK = 32'h1 << CMD_ACK_BIT;
  localparam int          LIMIT = 90000;
  logic        sys_clk = 1'b0;
  logic        reset = 1'b1;
  logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic        pwr_busy = 1'b0, backup = 1'b0;
  logic [7:0]  awaddr = 8'h00, araddr = 8'h00;
  logic [31:0] wdata = 32'h0;
  logic [3:0]  wstrb = 4'h0;
  logic        awready, wready, bvalid, arready, rvalid, csr_wr, dev_busy;
  logic [1:0]  bresp, rresp, r0;
  logic [31:0] rdata, d0;
  logic [7:0]  rd_addr, csr_rdata, wr_addr, wr_data, rx;
  int          n_mismatch = 0, num_checks = 0, cycles = 0, wr_cnt = 0;

  i2c_link_if link();
  rtc_i2c_controller rtc_i2c_controller_i (.sys_clk_in(sys_clk), .reset_in(reset), .link(link),
    .awaddr_in(awaddr), .awvalid_in(awvalid), .awready_out(awready), .wdata_in(wdata),
    .wstrb_in(wstrb), .wvalid_in(wvalid), .wready_out(wready), .bresp_out(bresp),
    .bvalid_out(bvalid), .bready_in(bready), .araddr_in(araddr), .arvalid_in(arvalid),
    .arready_out(arready), .rdata_out(rdata), .rresp_out(rresp), .rvalid_out(rvalid),
    .rready_in(rready));
  rtc_i2c_target rtc_i2c_target_i (.sys_clk_in(sys_clk), .reset_in(reset), .link(link),
    .powerup_busy_in(pwr_busy), .backup_supply_in(backup), .csr_rd_addr_out(rd_addr),
    .csr_rdata_in(csr_rdata), .csr_wr_out(csr_wr), .csr_wr_addr_out(wr_addr),
    .csr_wdata_out(wr_data), .busy_out(dev_busy));
  rtc_i2c_checker rtc_i2c_checker_i (.sys_clk_in(sys_clk), .reset_in(reset),
    .scl_line(link.scl_line), .sda_line(link.sda_line), .scl_host_oe_n(link.scl_host_oe_n),
    .sda_host_oe_n(link.sda_host_oe_n), .sda_dev_oe_n(link.sda_dev_oe_n),
    .powerup_busy_in(pwr_busy), .backup_supply_in(backup));

  // clock-space contents: a fixed pattern so any pointer slip shows
  function automatic logic [7:0] csr_val(input logic [7:0] a);
    return a ^ 8'h5a;
  endfunction : csr_val
  assign csr_rdata = csr_val(rd_addr);

  initial
  begin
    forever #(SYS_CLK_PERIOD_NS / 2) sys_clk = ~sys_clk;
  end

  always @(posedge sys_clk)
  begin
    cycles <= cycles + 1;
    if (csr_wr === 1'b1)
      wr_cnt <= wr_cnt + 1;
    if (cycles == LIMIT)
    begin
      n_mismatch = n_mismatch + 1;
      give_verdict();
    end
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    num_checks = num_checks + 1;
    if (seen !== exp)
    begin
      n_mismatch = n_mismatch + 1;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic give_verdict();
    $display("checks %0d mismatches %0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : give_verdict

  task automatic axi_write(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    logic aw_done;
    logic w_done;
    @(posedge sys_clk);
    aw_done = 1'b0;
    w_done = 1'b0;
    awaddr <= a;
    awvalid <= 1'b1;
    wdata <= d;
    wstrb <= 4'hf;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (!(aw_done && w_done))
    begin
      @(posedge sys_clk);
      if (awvalid && awready === 1'b1)
      begin
        awvalid <= 1'b0;
        aw_done = 1'b1;
      end
      if (wvalid && wready === 1'b1)
      begin
        wvalid <= 1'b0;
        w_done = 1'b1;
      end
    end
    do @(posedge sys_clk); while (bvalid !== 1'b1);
    r = bresp;
    bready <= 1'b0;
  endtask : axi_write

  task automatic axi_read(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    @(posedge sys_clk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do @(posedge sys_clk); while (arready !== 1'b1);
    arvalid <= 1'b0;
    do @(posedge sys_clk); while (rvalid !== 1'b1);
    d = rdata;
    r = rresp;
    rready <= 1'b0;
  endtask : axi_read

  // one link command through the controller, then the acknowledge it saw
  task automatic op(input logic [31:0] cmd, input logic [7:0] tx, input logic exp_nk);
    logic [31:0] d;
    logic [1:0]  r;
    axi_write(TXDATA_OFFSET, {24'h0, tx}, r);
    axi_write(CMD_OFFSET, cmd, r);
    do axi_read(STATUS_OFFSET, d, r); while (d[0] !== 1'b0);
    check({31'h0, d[1]}, {31'h0, exp_nk});
    axi_read(RXDATA_OFFSET, d, r);
    rx = d[7:0];
  endtask : op

  task automatic rnd_read(input logic [7:0] id, input logic [7:0] a, input logic [7:0] e0,
                          input logic [7:0] e1);
    op(ST | WR, id, 1'b0);
    op(WR, a, 1'b0);
    op(ST | WR, id | 8'h01, 1'b0);
    op(RD | AK, 8'h00, 1'b0);
    check({24'h0, rx}, {24'h0, e0});
    op(RD | SP, 8'h00, 1'b0);
    check({24'h0, rx}, {24'h0, e1});
  endtask : rnd_read

  initial
  begin
    repeat (20) @(posedge sys_clk);
    reset <= 1'b0;
    repeat (4) @(posedge sys_clk);
    check({30'h0, link.sda_line, link.scl_line}, 32'h3);
    check({31'h0, dev_busy}, 32'h0);
    axi_read(8'h40, d0, r0);
    check({30'h0, r0}, {30'h0, RESP_SLVERR});
    axi_write(8'h40, 32'h0, r0);
    check({30'h0, r0}, {30'h0, RESP_SLVERR});
    op(ST | WR, 8'hdf, 1'b0);
    axi_read(TXDATA_OFFSET, d0, r0);
    check(d0, 32'hdf);
    op(RD | SP, 8'h00, 1'b0);
    check({24'h0, rx}, {24'h0, csr_val(8'h00)});
    op(ST | WR, 8'hde, 1'b0);
    op(WR, 8'h10, 1'b0);
    op(WR | SP, 8'ha5, 1'b0);
    check({16'h0, wr_addr, wr_data}, 32'h10a5);
    op(ST | WR, 8'hae, 1'b0);
    op(WR, 8'h7f, 1'b0);
    op(WR, 8'h3c, 1'b0);
    op(WR | SP, 8'hc3, 1'b0);
    check(32'(wr_cnt), 32'h1);
    rnd_read(8'hae, 8'h7f, 8'h3c, 8'hc3);
    rnd_read(8'hde, 8'h2f, csr_val(8'h2f), csr_val(8'h00));
    op(ST | WR, 8'h20, 1'b1);
    op(WR | SP, 8'h00, 1'b1);
    pwr_busy <= 1'b1;
    op(ST | WR, 8'hde, 1'b1);
    op(SP, 8'h00, 1'b0);
    pwr_busy <= 1'b0;
    backup <= 1'b1;
    op(ST | WR, 8'hde, 1'b1);
    op(SP, 8'h00, 1'b0);
    backup <= 1'b0;
    rnd_read(8'hae, 8'h7f, 8'h3c, 8'hc3);
    give_verdict();
  end
endmodule : rtc_sram_i2c_target_port_test
